// ---- core/module_state_gate.sv ----
`timescale 1ns/1ps
module module_state_gate
    import power_sleep_ctrl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [1:0] state_in,
    input wire logic force_active_in,
    input wire logic assert_reset_in,
    input wire logic wait_reset_in,
    output logic reset_out,
    output logic clk_en_out
);

    // ------------------------------------------------------------
    // State to reset and clock mapping
    // ------------------------------------------------------------
    wire state_reset = (state_in == ST_RESET_CLOCK_OFF) ||
                       (state_in == ST_SYNC_RESET); // see [R14]
    wire state_clk = (state_in == ST_ENABLE) ||
                     (state_in == ST_SYNC_RESET); // see [R14]
    // Emulation overrides the programmed state
    wire next_reset = assert_reset_in || wait_reset_in ||
                      (state_reset && !force_active_in); // see [R11]
    wire next_clk = force_active_in || state_clk; // see [R11]

    // Clock gating alone keeps module contents: reset stays released
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reset_out <= 1'b1;
            clk_en_out <= 1'b1;
        end else begin
            reset_out <= next_reset; // see [R16]
            clk_en_out <= next_clk; // see [R1]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire emu_any = force_active_in || assert_reset_in || wait_reset_in;

    a_state_map_enable: assert property ( // see [R14]
        @(posedge mclk_in) disable iff (!resetn_in)
        (state_in == ST_ENABLE && !emu_any) |=> (!reset_out && clk_en_out))
        else $error("enable state did not map to run");

    a_disable_keeps: assert property ( // see [R16]
        @(posedge mclk_in) disable iff (!resetn_in)
        (state_in == ST_DISABLE && !emu_any) |=> (!reset_out && !clk_en_out))
        else $error("disable state asserted reset or ran clock");

    a_force_active_run: assert property ( // see [R11]
        @(posedge mclk_in) disable iff (!resetn_in)
        (force_active_in && !assert_reset_in && !wait_reset_in)
            |=> (!reset_out && clk_en_out))
        else $error("force active did not enable module");

endmodule // module_state_gate

// ---- core/power_sleep_ctrl.sv ----
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// Contract
// [R1] Controller governs power, per-module clock gating and module resets.
// [R2] Software sets each module's next state and starts transitions.
// [R3] Power-on reset sequencing runs in hardware without software.
// [R4] One permanent power domain holds all modules and reads ON.
// [R5] Every reset kind loads each module with its fixed default.
// [R6] Some defaults come from boot select pins sampled at reset.
// [R7] First async serial port enabled only for boot select 11.
// [R8] First card host enabled only for boot select 10.
// [R9] First sync serial port in reset only for boot select 01.
// [R10] External memory interface in reset only for boot select 10.
// [R11] Emulation requests also steer module clock and reset state.
// [R12] Timers, system, processor, bus modules enabled; others sync reset. Code keeps module 28, the second timer, in sync reset.
// [R13] DMA controller and transfer controllers follow memory interface.
// [R14] State maps to reset and clock: enable, disable, sync, off.
// [R15] Codes: off-reset 0, sync reset 1, disable 2, enable 3.
// [R16] Disable gates clock only, so module contents are kept.
module power_sleep_ctrl
    import power_sleep_ctrl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic [1:0] boot_select_pins_in,
    input wire logic [NUM_MODULES-1:0] emu_force_active_in,
    input wire logic [NUM_MODULES-1:0] emu_inhibit_sleep_in,
    input wire logic [NUM_MODULES-1:0] emu_assert_reset_in,
    input wire logic [NUM_MODULES-1:0] emu_wait_reset_in,
    input wire logic [NUM_MODULES-1:0] emu_block_reset_in,
    output logic power_domain_on_out,
    output wire logic [NUM_MODULES-1:0] mod_reset_out,
    output wire logic [NUM_MODULES-1:0] mod_clk_en_out
);

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_BOOT = 3'b001,
        SEQ_IDLE = 3'b010,
        SEQ_BUSY = 3'b100
    } seq_state_e;

    seq_state_e seq_state;
    seq_state_e next_seq_state;
    logic [3:0] trans_cnt;
    logic [1:0] boot_latch;
    logic [1:0] next_ctrl [NUM_MODULES];
    logic [1:0] cur_state [NUM_MODULES];

    // ------------------------------------------------------------
    // Bus address phase
    // ------------------------------------------------------------
    logic wr_pend;
    logic [3:0] wr_region;
    logic [7:0] wr_ofs;
    logic [IDX_W-1:0] wr_idx;

    wire addr_take = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
    wire addr_high_ok = (haddr_in[31:12] == ADDR_HIGH_ZERO);
    wire [3:0] a_region = haddr_in[11:8];
    wire [7:0] a_ofs = haddr_in[7:0];
    wire [IDX_W-1:0] a_idx = haddr_in[7:2];
    wire a_idx_ok = (a_idx < IDX_W'(NUM_MODULES));
    wire rd_take = addr_take && !hwrite_in;
    wire wr_take = addr_take && hwrite_in && addr_high_ok;

    assign hreadyout_out = 1'b1;
    assign hresp_out = HRESP_OKAY;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_pend <= 1'b0;
            wr_region <= REGION_GLOBAL;
            wr_ofs <= 8'h00;
            wr_idx <= '0;
        end else begin
            wr_pend <= wr_take;
            wr_region <= a_region;
            wr_ofs <= a_ofs;
            wr_idx <= a_idx;
        end
    end

    // ------------------------------------------------------------
    // Data phase decode
    // ------------------------------------------------------------
    wire busy = (seq_state == SEQ_BUSY);
    wire wr_ctrl = wr_pend && (wr_region == REGION_CTRL);
    wire go_write = wr_pend && (wr_region == REGION_GLOBAL) &&
                    (wr_ofs == OFS_GO_CMD) && hwdata_in[GO_BIT];
    wire apply_now = busy && (trans_cnt == TRANS_CNT_ZERO);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [1:0] rd_ctrl_val = a_idx_ok ? next_ctrl[a_idx] : 2'h0;
    wire [1:0] rd_cur_val = a_idx_ok ? cur_state[a_idx] : 2'h0;
    wire rd_rst_val = a_idx_ok ? mod_reset_out[a_idx] : 1'b0;
    wire rd_clk_val = a_idx_ok ? mod_clk_en_out[a_idx] : 1'b0;

    wire [31:0] rd_go_stat = 32'(busy) << BUSY_BIT;
    wire [31:0] rd_domain = (32'(power_domain_on_out) << DOMAIN_ON_BIT) |
                            (32'(boot_latch) << BOOT_LSB);
    wire [31:0] rd_mod_stat = 32'(rd_cur_val) |
                              (32'(rd_rst_val) << STAT_RESET_BIT) |
                              (32'(rd_clk_val) << STAT_CLK_BIT);

    wire sel_go_stat = (a_region == REGION_GLOBAL) && (a_ofs == OFS_GO_STAT);
    wire sel_domain = (a_region == REGION_GLOBAL) &&
                      (a_ofs == OFS_DOMAIN_STAT);
    wire sel_ctrl = (a_region == REGION_CTRL);
    wire sel_stat = (a_region == REGION_STAT);

    wire [31:0] next_rdata =
        !addr_high_ok ? 32'h00000000 :
        sel_go_stat ? rd_go_stat :
        sel_domain ? rd_domain :
        sel_ctrl ? 32'(rd_ctrl_val) :
        sel_stat ? rd_mod_stat : 32'h00000000;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hrdata_out <= 32'h00000000;
        end else if (rd_take) begin
            hrdata_out <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            SEQ_BOOT: next_seq_state = SEQ_IDLE; // see [R3]
            SEQ_IDLE: begin
                if (go_write) begin
                    next_seq_state = SEQ_BUSY; // see [R2]
                end
            end
            SEQ_BUSY: begin
                if (trans_cnt == TRANS_CNT_ZERO) begin
                    next_seq_state = SEQ_IDLE;
                end
            end
            default: next_seq_state = SEQ_BOOT;
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seq_state <= SEQ_BOOT;
            trans_cnt <= TRANS_CNT_ZERO;
        end else begin
            seq_state <= next_seq_state;
            if (seq_state == SEQ_IDLE && go_write) begin
                trans_cnt <= TRANS_CNT_LOAD;
            end else if (busy && trans_cnt != TRANS_CNT_ZERO) begin
                trans_cnt <= trans_cnt - TRANS_CNT_STEP;
            end
        end
    end

    // Boot pins caught in the first cycle after reset release
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            boot_latch <= BOOT_NAND;
            power_domain_on_out <= 1'b1;
        end else begin
            if (seq_state == SEQ_BOOT) begin
                boot_latch <= boot_select_pins_in; // see [R6]
            end
            power_domain_on_out <= 1'b1; // see [R4]
        end
    end

    // ------------------------------------------------------------
    // Per-module state
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
        wire wr_hit = wr_ctrl && (wr_idx == IDX_W'(g)) && !is_reserved(g);
        wire [1:0] want = next_ctrl[g];
        wire leave_enable = (cur_state[g] == ST_ENABLE) && (want != ST_ENABLE);
        wire into_reset = (want == ST_RESET_CLOCK_OFF) ||
                          (want == ST_SYNC_RESET);
        wire hold = (emu_inhibit_sleep_in[g] && leave_enable) ||
                    (emu_block_reset_in[g] && into_reset); // see [R11]

        always_ff @(posedge mclk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                next_ctrl[g] <= ST_SYNC_RESET;
                cur_state[g] <= ST_SYNC_RESET;
            end else if (seq_state == SEQ_BOOT) begin
                // see [R5] [R12] [R13]
                next_ctrl[g] <= default_state(g, boot_select_pins_in);
                cur_state[g] <= default_state(g, boot_select_pins_in);
            end else begin
                if (wr_hit) begin
                    next_ctrl[g] <= hwdata_in[1:0]; // see [R15]
                end
                if (apply_now && !hold) begin
                    cur_state[g] <= want; // see [R2]
                end
            end
        end

        module_state_gate u_gate (
            .mclk_in(mclk_in),
            .resetn_in(resetn_in),
            .state_in(cur_state[g]),
            .force_active_in(emu_force_active_in[g]),
            .assert_reset_in(emu_assert_reset_in[g]),
            .wait_reset_in(emu_wait_reset_in[g]),
            .reset_out(mod_reset_out[g]),
            .clk_en_out(mod_clk_en_out[g])
        );
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    // Boot cycle counts only once reset has been released
    wire in_boot = (seq_state == SEQ_BOOT) && resetn_in;

    sequence s_go_taken;
        (seq_state == SEQ_IDLE) && go_write;
    endsequence

    sequence s_busy_window;
        busy [*4] ##1 !busy;
    endsequence

    a_boot_to_idle: assert property ( // see [R3]
        in_boot |=> (seq_state == SEQ_IDLE) [*2])
        else $error("boot sequencing did not settle in idle");

    a_fixed_defaults: assert property ( // see [R12]
        in_boot |=> (cur_state[MOD_TIMER_FIRST] == ST_ENABLE) &&
                    (cur_state[MOD_TIMER_THIRD] == ST_ENABLE) &&
                    (cur_state[MOD_RSVD_LOW] == ST_RESET_CLOCK_OFF) &&
                    (cur_state[0] == ST_SYNC_RESET))
        else $error("fixed default states wrong after reset");

    a_serial_default: assert property ( // see [R7]
        in_boot |=> cur_state[MOD_SERIAL_FIRST] ==
            (($past(boot_select_pins_in) == BOOT_UART) ?
             ST_ENABLE : ST_SYNC_RESET))
        else $error("async serial port default wrong");

    a_card_default: assert property ( // see [R8]
        in_boot |=> cur_state[MOD_CARD_FIRST] ==
            (($past(boot_select_pins_in) == BOOT_CARD) ?
             ST_ENABLE : ST_SYNC_RESET))
        else $error("card host default wrong");

    a_sync_serial_default: assert property ( // see [R9]
        in_boot |=> cur_state[MOD_SYNC_SERIAL_FIRST] ==
            (($past(boot_select_pins_in) == BOOT_FLASH_ALT) ?
             ST_SYNC_RESET : ST_ENABLE))
        else $error("sync serial port default wrong");

    a_ext_mem_default: assert property ( // see [R10]
        in_boot |=> cur_state[MOD_EXT_MEM] ==
            (($past(boot_select_pins_in) == BOOT_CARD) ?
             ST_SYNC_RESET : ST_ENABLE))
        else $error("external memory interface default wrong");

    a_dma_default: assert property ( // see [R13]
        in_boot |=> (cur_state[MOD_DMA_CC] == cur_state[MOD_EXT_MEM]) &&
                    (cur_state[MOD_DMA_TC0] == cur_state[MOD_EXT_MEM]) &&
                    (cur_state[MOD_DMA_TC1] == cur_state[MOD_EXT_MEM]))
        else $error("dma defaults differ from memory interface");

    a_boot_latched: assert property ( // see [R6]
        in_boot |=> boot_latch == $past(boot_select_pins_in))
        else $error("boot select not captured");

    a_go_busy_time: assert property ( // see [R2]
        s_go_taken |=> s_busy_window)
        else $error("transition busy window not four cycles");

    a_go_applies: assert property ( // see [R2]
        (s_go_taken and
         (!emu_inhibit_sleep_in[MOD_TIMER_FIRST] &&
          !emu_block_reset_in[MOD_TIMER_FIRST]) [*5])
        ##0 1 |=> cur_state[MOD_TIMER_FIRST] ==
                  $past(next_ctrl[MOD_TIMER_FIRST], 1))
        else $error("transition did not apply next state");

    a_domain_on: assert property ( // see [R4]
        !in_boot |-> power_domain_on_out)
        else $error("permanent power domain not reported on");

    a_reserved_frozen: assert property ( // see [R1]
        (seq_state != SEQ_BOOT)
            |-> (cur_state[MOD_RSVD_HIGH] == ST_RESET_CLOCK_OFF) &&
                (next_ctrl[MOD_RSVD_HIGH] == ST_RESET_CLOCK_OFF))
        else $error("reserved module slot changed");

    a_ctrl_write: assert property ( // see [R15]
        (wr_ctrl && wr_idx == IDX_W'(MOD_TIMER_THIRD) && !in_boot)
            |=> next_ctrl[MOD_TIMER_THIRD] == $past(hwdata_in[1:0]))
        else $error("module control write not stored");

    a_busy_countdown: assert property ( // see [R2]
        (busy && trans_cnt != TRANS_CNT_ZERO)
            |=> busy && (trans_cnt == $past(trans_cnt) - TRANS_CNT_STEP))
        else $error("transition counter did not step down");

    a_inhibit_holds: assert property ( // see [R11]
        (apply_now && emu_inhibit_sleep_in[0] &&
         cur_state[0] == ST_ENABLE && next_ctrl[0] != ST_ENABLE)
            |=> cur_state[0] == ST_ENABLE)
        else $error("inhibit sleep did not keep module enabled");

    a_block_holds: assert property ( // see [R11]
        (apply_now && emu_block_reset_in[0] &&
         (next_ctrl[0] == ST_SYNC_RESET ||
          next_ctrl[0] == ST_RESET_CLOCK_OFF))
            |=> $stable(cur_state[0]))
        else $error("block reset did not keep module state");

    a_idle_holds_state: assert property ( // see [R2]
        (seq_state == SEQ_IDLE) |=> $stable(cur_state[0]))
        else $error("module state changed without a transition");

endmodule // power_sleep_ctrl

// ---- core/power_sleep_ctrl_pkg.sv ----
package power_sleep_ctrl_pkg;

    // ------------------------------------------------------------
    // Module states
    // ------------------------------------------------------------
    typedef logic [1:0] mod_state_t;
    localparam mod_state_t ST_RESET_CLOCK_OFF = 2'h0;
    localparam mod_state_t ST_SYNC_RESET = 2'h1;
    localparam mod_state_t ST_DISABLE = 2'h2;
    localparam mod_state_t ST_ENABLE = 2'h3;

    // ------------------------------------------------------------
    // Boot select codes
    // ------------------------------------------------------------
    localparam logic [1:0] BOOT_NAND = 2'h0;
    localparam logic [1:0] BOOT_FLASH_ALT = 2'h1;
    localparam logic [1:0] BOOT_CARD = 2'h2;
    localparam logic [1:0] BOOT_UART = 2'h3;

    // ------------------------------------------------------------
    // Module numbers
    // ------------------------------------------------------------
    localparam int NUM_MODULES = 42;
    localparam int IDX_W = 6;
    localparam int MOD_DMA_CC = 2;
    localparam int MOD_DMA_TC0 = 3;
    localparam int MOD_DMA_TC1 = 4;
    localparam int MOD_EXT_MEM = 14;
    localparam int MOD_CARD_FIRST = 15;
    localparam int MOD_RSVD_LOW = 16;
    localparam int MOD_SERIAL_FIRST = 19;
    localparam int MOD_SYNC_SERIAL_FIRST = 22;
    localparam int MOD_TIMER_FIRST = 27;
    localparam int MOD_TIMER_THIRD = 29;
    localparam int MOD_BUS_LAST = 38;
    localparam int MOD_RSVD_HIGH = 39;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [19:0] ADDR_HIGH_ZERO = 20'h00000;
    localparam logic [3:0] REGION_GLOBAL = 4'h0;
    localparam logic [3:0] REGION_CTRL = 4'h1;
    localparam logic [3:0] REGION_STAT = 4'h2;
    localparam logic [7:0] OFS_GO_CMD = 8'h10;
    localparam logic [7:0] OFS_GO_STAT = 8'h14;
    localparam logic [7:0] OFS_DOMAIN_STAT = 8'h20;
    localparam int GO_BIT = 0;
    localparam int BUSY_BIT = 0;
    localparam int DOMAIN_ON_BIT = 0;
    localparam int BOOT_LSB = 8;
    localparam int STAT_RESET_BIT = 8;
    localparam int STAT_CLK_BIT = 9;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TRANSITION_NS = 100;
    localparam int TRANSITION_CYCLES =
        (TRANSITION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TRANS_CNT_LOAD = 4'(TRANSITION_CYCLES - 1);
    localparam logic [3:0] TRANS_CNT_ZERO = 4'h0;
    localparam logic [3:0] TRANS_CNT_STEP = 4'h1;

    function automatic logic is_reserved(input int idx);
        return (idx == MOD_RSVD_LOW) || (idx == MOD_RSVD_HIGH);
    endfunction

    function automatic mod_state_t default_state(input int idx,
                                                 input logic [1:0] boot);
        mod_state_t st;
        st = ST_SYNC_RESET;
        case (idx)
            MOD_RSVD_LOW, MOD_RSVD_HIGH: st = ST_RESET_CLOCK_OFF;
            MOD_DMA_CC, MOD_DMA_TC0, MOD_DMA_TC1, MOD_EXT_MEM: // see [R10]
                st = (boot == BOOT_CARD) ? ST_SYNC_RESET : ST_ENABLE;
            MOD_CARD_FIRST: // see [R8]
                st = (boot == BOOT_CARD) ? ST_ENABLE : ST_SYNC_RESET;
            MOD_SERIAL_FIRST: // see [R7]
                st = (boot == BOOT_UART) ? ST_ENABLE : ST_SYNC_RESET;
            MOD_SYNC_SERIAL_FIRST: // see [R9]
                st = (boot == BOOT_FLASH_ALT) ? ST_SYNC_RESET : ST_ENABLE;
            MOD_TIMER_FIRST: st = ST_ENABLE;
            default:
                st = (idx >= MOD_TIMER_THIRD && idx <= MOD_BUS_LAST) ?
                     ST_ENABLE : ST_SYNC_RESET;
        endcase
        return st;
    endfunction

endpackage

// ---- dv/gated_modules_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Gated peripherals: one run counter per module
// ------------------------------------------------------------
module gated_modules_model
    import power_sleep_ctrl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [NUM_MODULES-1:0] mod_reset_in,
    input wire logic [NUM_MODULES-1:0] mod_clk_en_in,
    input wire logic [IDX_W-1:0] pick_in,
    output logic [15:0] count_out
);
    logic [15:0] count [NUM_MODULES];

    assign count_out = count[pick_in];

    // Counter runs only on a live clock, so a gated module out of reset keeps its count
    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < NUM_MODULES; i++) begin
            if (mod_reset_in[i]) begin
                count[i] <= 16'h0000;
            end else if (mod_clk_en_in[i]) begin
                count[i] <= count[i] + 16'h0001;
            end
        end
    end
endmodule // gated_modules_model

// ---- dv/module_power_reset_defaults_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module module_power_reset_defaults_tb import power_sleep_ctrl_pkg::*;;
    typedef struct packed {
        logic [5:0] idx;
        logic [3:0] en_boot;
    } row_s;
    // ------------------------------------------------------------
    // Default table: bit b of en_boot set means Enable for boot b
    // ------------------------------------------------------------
    localparam row_s ROWS [14] = '{
        '{6'h02, 4'hB}, '{6'h03, 4'hB}, '{6'h04, 4'hB},
        '{6'h0E, 4'hB},
        '{6'h0F, 4'h4},
        '{6'h13, 4'h8},
        '{6'h16, 4'hD},
        '{6'h1B, 4'hF}, '{6'h1D, 4'hF}, '{6'h1F, 4'hF},
        '{6'h26, 4'hF}, '{6'h00, 4'h0}, '{6'h1C, 4'h0},
        '{6'h29, 4'h0}
    };
    logic mclk_in, resetn_in, hsel_in, hwrite_in, hresp, pwr_on;
    logic [1:0] htrans_in, boot;
    logic [2:0] hsize_in;
    logic [31:0] haddr_in, hwdata_in, hrdata, rd;
    wire logic hready;
    wire logic [NUM_MODULES-1:0] mod_rst, mod_clk;
    logic [NUM_MODULES-1:0] emu_fa, emu_is, emu_ar, emu_wr, emu_br;
    logic [15:0] cnt, c;
    int mismatches, samples_checked;

    power_sleep_ctrl power_sleep_ctrl_i (.mclk_in(mclk_in),
        .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hready), .hreadyout_out(hready),
        .hresp_out(hresp), .hrdata_out(hrdata), .boot_select_pins_in(boot),
        .emu_force_active_in(emu_fa), .emu_inhibit_sleep_in(emu_is),
        .emu_assert_reset_in(emu_ar), .emu_wait_reset_in(emu_wr),
        .emu_block_reset_in(emu_br), .power_domain_on_out(pwr_on),
        .mod_reset_out(mod_rst), .mod_clk_en_out(mod_clk));
    gated_modules_model gated_modules_model_i (.mclk_in(mclk_in),
        .mod_reset_in(mod_rst), .mod_clk_en_in(mod_clk),
        .pick_in(6'h00), .count_out(cnt));

    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end

    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd);
        haddr_in <= a;
        hwrite_in <= wr;
        htrans_in <= HTRANS_NONSEQ;
        wait_ready();
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        wait_ready();
        rd = hrdata;
        `CHK(hresp, HRESP_OKAY)
    endtask

    task automatic go();
        int n;
        xfer(1'b1, {24'h000000, OFS_GO_CMD}, 32'h00000001);
        xfer(1'b0, {24'h000000, OFS_GO_STAT}, 32'h00000000);
        `CHK(rd[BUSY_BIT], 1'b1)
        n = 0;
        while (rd[BUSY_BIT] !== 1'b0 && n < 20) begin
            xfer(1'b0, {24'h000000, OFS_GO_STAT}, 32'h00000000);
            n++;
        end
        if (rd[BUSY_BIT] !== 1'b0) begin
            mismatches++;
            wrap_up();
        end
        repeat (2) @(posedge mclk_in);
    endtask

    task automatic set_go(input int i, input mod_state_t st);
        xfer(1'b1, 32'h00000100 + 32'(4 * i), {30'h0, st});
        go();
    endtask

    task automatic chk_mod(input int i, input mod_state_t st);
        `CHK(mod_rst[i], ~st[1])
        `CHK(mod_clk[i], st[0])
        xfer(1'b0, 32'h00000200 + 32'(4 * i), 32'h00000000);
        `CHK(rd[1:0], st)
        `CHK(rd[9:8], {st[0], ~st[1]})
    endtask

    task automatic do_reset(input logic [1:0] b);
        resetn_in <= 1'b0;
        boot <= b;
        repeat (3) @(posedge mclk_in);
        `CHK(mod_rst, {NUM_MODULES{1'b1}})
        `CHK(pwr_on, 1'b1)
        resetn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
    endtask

    initial begin
        mismatches = 0;
        samples_checked = 0;
        resetn_in = 1'b0;
        hsel_in = 1'b1;
        haddr_in = 32'h00000000;
        htrans_in = 2'h0;
        hwrite_in = 1'b0;
        hsize_in = 3'h2;
        hwdata_in = 32'h00000000;
        boot = 2'h0;
        {emu_fa, emu_is, emu_ar, emu_wr, emu_br} = '0;
        @(posedge mclk_in);
        for (int b = 0; b < 4; b++) begin
            do_reset(2'(b));
            xfer(1'b0, {24'h000000, OFS_DOMAIN_STAT}, 32'h00000000);
            `CHK(rd[9:0], {2'(b), 7'h00, 1'b1})
            for (int r = 0; r < 14; r++) begin
                chk_mod(ROWS[r].idx, ROWS[r].en_boot[b] ? ST_ENABLE :
                        ST_SYNC_RESET);
            end
            chk_mod(MOD_RSVD_HIGH, ST_RESET_CLOCK_OFF);
        end
        for (int s = 0; s < 4; s++) begin
            set_go(0, mod_state_t'(s));
            chk_mod(0, mod_state_t'(s));
        end
        set_go(0, ST_DISABLE);
        c = cnt;
        repeat (4) @(posedge mclk_in);
        `CHK(cnt, c)
        set_go(0, ST_ENABLE);
        `CHK(cnt > c, 1'b1)
        emu_is[0] <= 1'b1;
        set_go(0, ST_DISABLE);
        chk_mod(0, ST_ENABLE);
        emu_is[0] <= 1'b0;
        emu_br[0] <= 1'b1;
        set_go(0, ST_SYNC_RESET);
        chk_mod(0, ST_ENABLE);
        emu_br[0] <= 1'b0;
        set_go(0, ST_SYNC_RESET);
        emu_wr[0] <= 1'b1;
        set_go(0, ST_ENABLE);
        `CHK(mod_rst[0], 1'b1)
        emu_wr[0] <= 1'b0;
        repeat (2) @(posedge mclk_in);
        `CHK(mod_rst[0], 1'b0)
        set_go(0, ST_RESET_CLOCK_OFF);
        emu_fa[0] <= 1'b1;
        repeat (2) @(posedge mclk_in);
        `CHK({mod_rst[0], mod_clk[0]}, 2'h1)
        emu_ar[0] <= 1'b1;
        repeat (2) @(posedge mclk_in);
        `CHK(mod_rst[0], 1'b1)
        xfer(1'b1, 32'h00000140, 32'h00000003);
        xfer(1'b0, 32'h00000140, 32'h00000000);
        `CHK(rd, 32'h00000000)
        xfer(1'b1, 32'h00000174, 32'h00000002);
        xfer(1'b0, 32'h00000174, 32'h00000000);
        `CHK(rd, 32'h00000002)
        xfer(1'b0, 32'h00001020, 32'h00000000);
        `CHK(rd, 32'h00000000)
        wrap_up();
    end
endmodule // module_power_reset_defaults_tb
